// [logic/kwu_top.sv]
// key wake interrupt unit: seven wake pins, one flag, axi4-lite registers
// assumes pins asynchronous, power mode levels from the system controller
//
// Overview of operation
// - up to eight wake pins, each with its own detect enable bit
// - seven pins fitted in this variant, one block instance
// - per pin polarity; edge only, or edge plus level sensing
// - all enabled pins merge into one maskable interrupt
// - keeps running in wait mode when enabled beforehand
// - detection wakes from wait when request enable is 1
// - keeps detecting in clocks-off retained stop only while the bus clock runs
// - enabled pin wakes from clocks-off stop when request enable set
// - disabled, no detection or flagging, during deep power-down modes
// - all state and configuration reset after deep power-down
// - background debug halt does not stop detection or requests
// - edges seen by bus clock sampling: deasserted then asserted
// - no new edge until every enabled input is deasserted
// - detection sets shared flag; request while flag and enable set
// - ack write clears flag, unless level mode and a pin asserted
//
// Chosen here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "kwu_defines.svh"
module kwu_top #(
    parameter int NPINS = 7,
    parameter int AW    = 12
) (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   ce,
    input  wire logic [NPINS-1:0]       wake_input_pin,
    input  wire kwu_pkg::kwu_pwr_t      pwr_mode,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [AW-1:0]          s_axi_awaddr,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    output logic [1:0]                  s_axi_bresp,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    input  wire logic [AW-1:0]          s_axi_araddr,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        irq,
    output logic                        wake_req,
    output logic                        evt_irq
);
    import kwu_pkg::*;

    typedef struct packed {
        kwu_cfg_t     cfg;
        logic         flag;
        logic         armed;
        logic         wake;
        logic         irq;
        logic [1:0]   evt_stat;
        logic [1:0]   evt_mask;
        logic         evt_irq;
        kwu_bus_st_t  wst;
        logic         aw_got;
        logic         w_got;
        logic [AW-1:0] waddr;
        logic [31:0]  wdata;
        logic [3:0]   wstrb;
        logic         awready;
        logic         wready;
        logic         bvalid;
        logic [1:0]   bresp;
        kwu_bus_st_t  rst_s;
        logic         arready;
        logic         rvalid;
        logic [31:0]  rdata;
        logic [1:0]   rresp;
    } kwu_st_t;

    kwu_st_t st_q;
    kwu_st_t st_d;

    logic [NPINS-1:0] asserted;
    logic [NPINS-1:0] rose;
    logic             deep;
    logic             any_asserted;
    logic             detect;
    logic             do_write;
    logic             ack;
    logic             do_read;
    logic             rd_stat;
    logic [31:0]      rd_val;
    logic [1:0]       rd_resp;
    logic [1:0]       wr_resp;

    // deep modes hold the block in reset so wake-up finds it cleared
    assign deep = pwr_mode.deep_a_mode | pwr_mode.deep_b_mode;

    kwu_detect #(
        .N (NPINS)
    ) u_det (
        .clk      (clk),
        .rst_n    (rst_n & ~deep),
        .ce       (ce),
        .pin      (wake_input_pin),
        .enable   (st_q.cfg.pin_en[NPINS-1:0]),
        .polarity (st_q.cfg.polarity[NPINS-1:0]),
        .asserted (asserted),
        .rose     (rose)
    );

    assign any_asserted = |asserted;
    // edge found only while armed; level mode also counts a held pin
    assign detect = (st_q.armed & (|rose))
                  | (st_q.cfg.lvl_mode & any_asserted);

    assign do_write = st_q.aw_got & st_q.w_got & (st_q.wst == KWU_ST_IDLE);
    assign ack = do_write && st_q.waddr == `KWU_OFS_CTRL && st_q.wstrb[0]
               && st_q.wdata[`KWU_BIT_ACK];
    assign do_read = s_axi_arvalid & st_q.arready;
    assign rd_stat = do_read && s_axi_araddr == `KWU_OFS_EVT_STAT;

    always_comb begin
        rd_resp = `KWU_RESP_OKAY;
        rd_val  = '0;
        unique case (s_axi_araddr)
            `KWU_OFS_CTRL: begin
                rd_val[`KWU_BIT_FLAG]     = st_q.flag;
                rd_val[`KWU_BIT_IRQ_EN]   = st_q.cfg.irq_en;
                rd_val[`KWU_BIT_LVL_MODE] = st_q.cfg.lvl_mode;
            end
            `KWU_OFS_PIN_EN:   rd_val[7:0] = st_q.cfg.pin_en;
            `KWU_OFS_POLARITY: rd_val[7:0] = st_q.cfg.polarity;
            `KWU_OFS_EVT_STAT: rd_val[1:0] = st_q.evt_stat;
            `KWU_OFS_EVT_MASK: rd_val[1:0] = st_q.evt_mask;
            `KWU_OFS_PWR: begin
                rd_val[`KWU_BIT_WAIT]   = pwr_mode.wait_mode;
                rd_val[`KWU_BIT_CLOCKS_OFF_RETAINED_MODE]  = pwr_mode.clocks_off_retained_mode_mode;
                rd_val[`KWU_BIT_DEEP_A] = pwr_mode.deep_a_mode;
                rd_val[`KWU_BIT_DEEP_B] = pwr_mode.deep_b_mode;
            end
            default: rd_resp = `KWU_RESP_SLVERR;
        endcase
    end

    always_comb begin
        unique case (st_q.waddr)
            `KWU_OFS_CTRL, `KWU_OFS_PIN_EN, `KWU_OFS_POLARITY,
            `KWU_OFS_EVT_STAT, `KWU_OFS_EVT_MASK, `KWU_OFS_PWR:
                wr_resp = `KWU_RESP_OKAY;
            default: wr_resp = `KWU_RESP_SLVERR;
        endcase
    end

    always_comb begin
        st_d = st_q;
        // write address and data accepted in either order
        if (s_axi_awvalid && st_q.awready) begin
            st_d.aw_got  = 1'b1;
            st_d.waddr   = s_axi_awaddr;
            st_d.awready = 1'b0;
        end
        if (s_axi_wvalid && st_q.wready) begin
            st_d.w_got  = 1'b1;
            st_d.wdata  = s_axi_wdata;
            st_d.wstrb  = s_axi_wstrb;
            st_d.wready = 1'b0;
        end
        if (do_write) begin
            st_d.wst    = KWU_ST_RESP;
            st_d.bvalid = 1'b1;
            st_d.bresp  = wr_resp;
            if (st_q.wstrb[0]) begin
                unique case (st_q.waddr)
                    `KWU_OFS_CTRL: begin
                        st_d.cfg.irq_en   = st_q.wdata[`KWU_BIT_IRQ_EN];
                        st_d.cfg.lvl_mode = st_q.wdata[`KWU_BIT_LVL_MODE];
                    end
                    // pins above the fitted count stay disabled
                    `KWU_OFS_PIN_EN:   st_d.cfg.pin_en = st_q.wdata[7:0]
                                          & 8'((1 << NPINS) - 1);
                    `KWU_OFS_POLARITY: st_d.cfg.polarity = st_q.wdata[7:0];
                    `KWU_OFS_EVT_MASK: st_d.evt_mask = st_q.wdata[1:0];
                    default: ;
                endcase
            end
        end
        if (st_q.wst == KWU_ST_RESP && s_axi_bready) begin
            st_d.wst     = KWU_ST_IDLE;
            st_d.bvalid  = 1'b0;
            st_d.aw_got  = 1'b0;
            st_d.w_got   = 1'b0;
            st_d.awready = 1'b1;
            st_d.wready  = 1'b1;
        end

        if (do_read) begin
            st_d.arready = 1'b0;
            st_d.rvalid  = 1'b1;
            st_d.rdata   = rd_val;
            st_d.rresp   = rd_resp;
            st_d.rst_s   = KWU_ST_RESP;
        end
        if (st_q.rst_s == KWU_ST_RESP && s_axi_rready) begin
            st_d.rvalid  = 1'b0;
            st_d.arready = 1'b1;
            st_d.rst_s   = KWU_ST_IDLE;
        end

        // re-arm only once every enabled pin is back at rest
        if (!any_asserted) begin
            st_d.armed = 1'b1;
        end else if (|rose) begin
            st_d.armed = 1'b0;
        end
        // flag: set beats ack; level mode keeps it while a pin asserted
        if (ack) begin
            st_d.flag = 1'b0;
        end
        if (detect) begin
            st_d.flag = 1'b1;
        end
        st_d.irq = st_d.flag & st_d.cfg.irq_en;
        // wake from wait or clocks-off stop needs the request enabled
        st_d.wake = (pwr_mode.wait_mode | pwr_mode.clocks_off_retained_mode_mode)
                  & st_d.irq;

        if (rd_stat) begin
            st_d.evt_stat = '0;
        end
        if (detect) begin
            st_d.evt_stat[`KWU_EVT_DETECT] = 1'b1;
        end
        if (st_d.wake && !st_q.wake) begin
            st_d.evt_stat[`KWU_EVT_WAKE] = 1'b1;
        end
        st_d.evt_irq = |(st_d.evt_stat & st_d.evt_mask);
    end

    always_ff @(posedge clk) begin
        if (!rst_n || deep) begin
            st_q         <= '0;
            st_q.wst     <= KWU_ST_IDLE;
            st_q.rst_s   <= KWU_ST_IDLE;
            st_q.awready <= 1'b1;
            st_q.wready  <= 1'b1;
            st_q.arready <= 1'b1;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    assign s_axi_awready = st_q.awready;
    assign s_axi_wready  = st_q.wready;
    assign s_axi_bvalid  = st_q.bvalid;
    assign s_axi_bresp   = st_q.bresp;
    assign s_axi_arready = st_q.arready;
    assign s_axi_rvalid  = st_q.rvalid;
    assign s_axi_rdata   = st_q.rdata;
    assign s_axi_rresp   = st_q.rresp;
    assign irq           = st_q.irq;
    assign wake_req      = st_q.wake;
    assign evt_irq       = st_q.evt_irq;

    property p_irq_follows_flag;
        @(posedge clk) disable iff (!rst_n || deep || !ce)
        irq == (st_q.flag && st_q.cfg.irq_en);
    endproperty
    a_irq_follows_flag: assert property (p_irq_follows_flag)
        else $error("irq missing while flag and enable set");

    property p_no_irq_unmasked;
        @(posedge clk) disable iff (!rst_n)
        !st_q.cfg.irq_en |-> !irq || $past(st_q.cfg.irq_en);
    endproperty
    a_no_irq_unmasked: assert property (p_no_irq_unmasked)
        else $error("irq raised while request disabled");

    property p_deep_clears;
        @(posedge clk) disable iff (!rst_n)
        deep |=> (!st_q.flag && st_q.cfg.pin_en == 8'h00 && !irq);
    endproperty
    a_deep_clears: assert property (p_deep_clears)
        else $error("state not cleared in deep power-down");

    property p_ack_clears;
        @(posedge clk) disable iff (!rst_n || deep || !ce)
        (ack && !detect) |=> !st_q.flag;
    endproperty
    a_ack_clears: assert property (p_ack_clears)
        else $error("ack did not clear flag");

    property p_level_holds;
        @(posedge clk) disable iff (!rst_n || deep || !ce)
        (ack && st_q.cfg.lvl_mode && any_asserted) |=> st_q.flag;
    endproperty
    a_level_holds: assert property (p_level_holds)
        else $error("flag cleared while level asserted");

    property p_disarmed_no_edge;
        @(posedge clk) disable iff (!rst_n || deep || !ce)
        (!st_q.armed && !st_q.cfg.lvl_mode && !st_q.flag && !ack)
            |=> !st_q.flag;
    endproperty
    a_disarmed_no_edge: assert property (p_disarmed_no_edge)
        else $error("edge taken before inputs returned to rest");

    property p_wake_wait;
        @(posedge clk) disable iff (!rst_n || deep || !ce)
        (pwr_mode.wait_mode && st_q.flag && st_q.cfg.irq_en && !do_write) |=> wake_req;
    endproperty
    a_wake_wait: assert property (p_wake_wait)
        else $error("no wake from wait");

    property p_disabled_pins;
        @(posedge clk) disable iff (!rst_n || deep || !ce)
        (st_q.cfg.pin_en == 8'h00 && !st_q.flag) |=> !st_q.flag;
    endproperty
    a_disabled_pins: assert property (p_disabled_pins)
        else $error("disabled pin seen as asserted");

    property p_clocks_off_retained_mode_async;
        @(posedge clk) disable iff (!rst_n || deep || !ce)
        (pwr_mode.clocks_off_retained_mode_mode && st_q.cfg.irq_en && st_q.armed && (|rose) && !do_write)
            |=> wake_req;
    endproperty
    a_clocks_off_retained_mode_async: assert property (p_clocks_off_retained_mode_async)
        else $error("no wake from clocks-off stop on a fresh edge");
endmodule

// [logic/kwu_defines.svh]
// register offsets, field positions and reset values of the key wake block
// assumes a 32-bit axi4-lite slave with one aligned word per register
`ifndef KWU_DEFINES_SVH
`define KWU_DEFINES_SVH
`define KWU_OFS_CTRL      12'h000
`define KWU_OFS_PIN_EN    12'h004
`define KWU_OFS_POLARITY  12'h008
`define KWU_OFS_EVT_STAT  12'h00C
`define KWU_OFS_EVT_MASK  12'h010
`define KWU_OFS_PWR       12'h014
`define KWU_BIT_LVL_MODE  0
`define KWU_BIT_IRQ_EN    1
`define KWU_BIT_ACK       2
`define KWU_BIT_FLAG      3
`define KWU_BIT_WAIT      0
`define KWU_BIT_CLOCKS_OFF_RETAINED_MODE     1
`define KWU_BIT_DEEP_A    2
`define KWU_BIT_DEEP_B    3
`define KWU_EVT_DETECT    0
`define KWU_EVT_WAKE      1
`define KWU_RESP_OKAY     2'h0
`define KWU_RESP_SLVERR   2'h2
`define KWU_RST_BYTE      8'h00
`endif

// [logic/kwu_pkg.sv]
// types shared by the key wake block
// assumes kwu_defines.svh for register numbers; bus state codes are set here
package kwu_pkg;
    typedef struct packed {
        logic        lvl_mode;
        logic        irq_en;
        logic [7:0]  pin_en;
        logic [7:0]  polarity;
    } kwu_cfg_t;

    typedef struct packed {
        logic        wait_mode;
        logic        clocks_off_retained_mode_mode;
        logic        deep_a_mode;
        logic        deep_b_mode;
    } kwu_pwr_t;

    typedef enum logic [2:0] {
        KWU_ST_IDLE = 3'b001,
        KWU_ST_RESP = 3'b010,
        KWU_ST_DONE = 3'b100
    } kwu_bus_st_t;
endpackage

// [logic/kwu_detect.sv]
// per-pin synchroniser and edge/level qualification
// assumes pins asynchronous; flops run on the bus clock
`timescale 1ns/1ns
module kwu_detect #(
    parameter int N = 7
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic [N-1:0] pin,
    input  wire logic [N-1:0] enable,
    input  wire logic [N-1:0] polarity,
    output logic [N-1:0]      asserted,
    output logic [N-1:0]      rose
);
    typedef struct packed {
        logic [N-1:0] s1;
        logic [N-1:0] s2;
        logic [N-1:0] prev;
    } kwu_det_st_t;

    kwu_det_st_t st_q;
    kwu_det_st_t st_d;

    always_comb begin
        st_d      = st_q;
        st_d.s1   = pin;
        st_d.s2   = st_q.s1;
        st_d.prev = asserted;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_pin
            // polarity 0 means low is asserted
            assign asserted[i] = enable[i] & ~(st_q.s2[i] ^ polarity[i]);
            assign rose[i]     = asserted[i] & ~st_q.prev[i];
        end
    endgenerate
endmodule

// [sim/kwu_keys.sv]
// key switch partner: drives the seven wake pins from requested levels
// assumes the bench sets levels just after a rising edge; slow adds two cycles of lag
`timescale 1ns/1ns
module kwu_keys (
    input  wire logic       clk,
    input  wire logic [6:0] level,
    input  wire logic       slow,
    output logic [6:0]      pins
);
    logic [6:0] lag1_q;
    logic [6:0] lag2_q;

    // switches always drive their line, so no released state exists
    always @(posedge clk) begin
        lag1_q <= level;
        lag2_q <= lag1_q;
    end
    // slow contacts settle late, so the pin change lands off the request edge
    assign pins = slow ? lag2_q : level;
endmodule

// [sim/tb_top.sv]
// self-checking bench of the key wake block against a behavioural model
// assumes registers at the byte offsets of kwu_defines.svh, axi4-lite master here
`timescale 1ns/1ns
`include "kwu_defines.svh"
module tb_top;
    import kwu_pkg::*;
    logic clk = 0, rst_n = 0, slow = 0, ce = 1;
    logic [6:0] lvl_pins = 7'h7f, pins;
    kwu_pwr_t pwr = '0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, irq, wake_req, evt_irq;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] v;
    logic [6:0] m_en = 0, m_pol = 0, m_prev = 0;
    bit m_lvl = 0, m_ie = 0, m_flag = 0, m_arm = 1;
    int miscompares = 0, checked = 0;

    always #4 clk = ~clk;
    kwu_keys keys (.clk(clk), .level(lvl_pins), .slow(slow), .pins(pins));
    kwu_top #(.NPINS(7), .AW(12)) DUT (
        .clk(clk), .rst_n(rst_n), .ce(ce), .wake_input_pin(pins), .pwr_mode(pwr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .irq(irq), .wake_req(wake_req),
        .evt_irq(evt_irq));

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s response expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic timeout(input string what);
        miscompares++;
        $display("[ERR] %s expected handshake seen timeout", what);
        end_of_test();
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        bit ta, tw;
        ta = 0;
        tw = 0;
        n = 0;
        @(posedge clk);
        awaddr <= a; wdata <= d; wstrb <= 4'hf; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(posedge clk);
            n++;
            if (!ta && awready) begin ta = 1; awvalid <= 0; end
            if (!tw && wready) begin tw = 1; wvalid <= 0; end
        end while (!(ta && tw && bvalid) && n < 40);
        if (!(ta && tw && bvalid)) timeout("write");
        r = bresp;
        bready <= 0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        bit ta, got;
        ta = 0;
        n = 0;
        @(posedge clk);
        araddr <= a; arvalid <= 1; rready <= 1;
        do begin
            @(posedge clk);
            n++;
            got = ta && rvalid;
            if (!ta && arready) begin ta = 1; arvalid <= 0; end
        end while (!got && n < 40);
        if (!got) timeout("read");
        d = rdata;
        r = rresp;
        rready <= 0;
    endtask

    function automatic logic [6:0] asr();
        return m_en & ~(lvl_pins ^ m_pol);
    endfunction
    // model settles after every change; edge needs a fresh assertion while armed
    task automatic settle();
        repeat (10) @(posedge clk);
        if (asr() == 0) m_arm = 1;
        else if (m_arm && (asr() & ~m_prev) != 0) begin m_flag = 1; m_arm = 0; end
        if (m_lvl && asr() != 0) m_flag = 1;
        m_prev = asr();
    endtask
    task automatic check_ctrl();
        rd(`KWU_OFS_CTRL, v, resp);
        chk("ctrl", {28'h0, m_flag, 1'b0, m_ie, m_lvl}, v);
        chk("irq", m_flag & m_ie, irq);
        chk("wake_req", m_flag & m_ie & (pwr.wait_mode | pwr.clocks_off_retained_mode_mode), wake_req);
    endtask
    task automatic cfg(input logic [6:0] en, input logic [6:0] pol, input bit lv, input bit ie);
        wr(`KWU_OFS_PIN_EN, 32'h0, resp);
        wr(`KWU_OFS_POLARITY, {25'h0, pol}, resp);
        m_en = 0; m_pol = pol; settle();
        wr(`KWU_OFS_CTRL, {29'h0, 1'b1, ie, lv}, resp);
        wr(`KWU_OFS_PIN_EN, {25'h0, en}, resp);
        m_en = en; m_lvl = lv; m_ie = ie; settle();
    endtask
    task automatic ack();
        wr(`KWU_OFS_CTRL, {29'h0, 1'b1, m_ie, m_lvl}, resp);
        m_flag = m_lvl && asr() != 0;
        settle();
        check_ctrl();
    endtask
    task automatic step(input logic [6:0] p);
        @(posedge clk);
        lvl_pins <= p;
        settle();
        check_ctrl();
    endtask

    initial begin
        int i;
        logic [6:0] pol;
        void'($urandom(32'hf1e7c3c7));
        repeat (2) @(posedge clk);
        rst_n <= 1;
        repeat (4) @(posedge clk);
        for (i = 0; i < 6; i++) begin
            rd(12'(4 * i), v, resp);
            chk("reset value", 32'h0, v);
        end
        rd(12'h018, v, resp);
        chk_resp("unmapped read", `KWU_RESP_SLVERR, resp);
        chk("unmapped data", 32'h0, v);
        wr(12'h018, 32'hffff_ffff, resp);
        chk_resp("unmapped write", `KWU_RESP_SLVERR, resp);
        wr(`KWU_OFS_PIN_EN, 32'h0000_00ff, resp);
        rd(`KWU_OFS_PIN_EN, v, resp);
        chk("pin enable width", 32'h0000_007f, v);
        $display("test registers done");
        for (i = 0; i < 8; i++) begin
            pol = 7'($urandom);
            slow <= i[0];
            lvl_pins <= ~pol;
            cfg(7'h7f, pol, 0, i < 6);
            ack();
            step(~pol ^ 7'(1 << ($urandom % 7)));
        end
        slow <= 0;
        $display("test edges done");
        lvl_pins <= 7'h7f;
        cfg(7'h77, 7'h00, 0, 1);
        ack();
        step(7'h7e);
        ack();
        step(7'h7c);
        step(7'h74);
        step(7'h7f);
        ack();
        step(7'h77);
        step(7'h7d);
        $display("test rearm done");
        lvl_pins <= 7'h00;
        cfg(7'h7f, 7'h7f, 1, 1);
        ack();
        // a pin pulse while the enable is low must not be seen at all
        ce <= 0;
        lvl_pins <= 7'h08;
        repeat (10) @(posedge clk);
        chk("irq while frozen", 32'h0, irq);
        lvl_pins <= 7'h00;
        ce <= 1;
        settle();
        check_ctrl();
        step(7'h04);
        ack();
        step(7'h00);
        ack();
        $display("test level done");
        pwr.wait_mode <= 1;
        step(7'h01);
        rd(`KWU_OFS_PWR, v, resp);
        chk("power modes", 32'h0000_0001, v);
        step(7'h00);
        ack();
        pwr.wait_mode <= 0;
        pwr.clocks_off_retained_mode_mode <= 1;
        step(7'h10);
        pwr.clocks_off_retained_mode_mode <= 0;
        step(7'h00);
        ack();
        $display("test power done");
        wr(`KWU_OFS_EVT_MASK, 32'h0000_0001, resp);
        rd(`KWU_OFS_EVT_STAT, v, resp);
        chk("detect and wake events", 32'h0000_0003, v);
        repeat (3) @(posedge clk);
        chk("evt_irq idle", 32'h0, evt_irq);
        step(7'h20);
        chk("evt_irq set", 32'h1, evt_irq);
        step(7'h00);
        ack();
        rd(`KWU_OFS_EVT_STAT, v, resp);
        chk("event status", 32'h0000_0001, v);
        repeat (3) @(posedge clk);
        chk("evt_irq cleared", 32'h0, evt_irq);
        $display("test events done");
        pwr.deep_a_mode <= 1;
        repeat (4) @(posedge clk);
        lvl_pins <= 7'h7f;
        repeat (8) @(posedge clk);
        chk("irq in deep mode", 32'h0, irq);
        pwr.deep_a_mode <= 0;
        repeat (4) @(posedge clk);
        m_en = 0; m_pol = 0; m_lvl = 0; m_ie = 0; m_flag = 0; m_arm = 1; m_prev = 0;
        for (i = 0; i < 3; i++) begin
            rd(12'(4 * i), v, resp);
            chk("after deep mode", 32'h0, v);
        end
        $display("test deep done");
        end_of_test();
    end
endmodule
